/* rtl/sir_port.v */
// Purpose: i2c target read port of a magnetic sensor with apb control
// Assumes: scl and sda sampled by core_clk, far faster than the bus
// Notes: register contents come from the sensor core via REG_RDATA
//
// The register addresses and the APB slave port are this design's own decisions.
`include "sir_map.vh"
`timescale 1ns/10ps
`default_nettype none
// Operation
// (RL1) two-byte mode addressed start, one-byte at zero
// (RL2) pointer increments after each data byte
// (RL3) reading past map leaves sda released
// (RL4) master nack releases sda until stop
// (RL5) two-byte read: address, trigger/register, data
// (RL6) master sets protocol bit in register 11h
// (RL7) one-byte read sends data after address ack
// (RL8) collision avoidance watches every start and stop
// (RL9) start suppresses interrupt pulses
// (RL10) withheld interrupt released after stop
// (RL11) master should enable collision avoidance with interrupt
// (RL12) stretch scl: converting, read addressed, before ack
// (RL13) read data starts after conversion ends
// (RL14) never stretch during write transfers
// (RL15) stretching in both read modes
// (RL16) four ff/ff/00/00 frames then wait resets device
// (RL17) master reconfigures after bus reset
// (RL18) spike start blocks interrupts until stop
// (RL19) master issues bus reset after power-up
// (RL20) master clears stuck sda by bus reset
// (RL21) master resets bus after own reset
// (RL22) no repeated start supported
// (RL23) trigger bits choose conversion start point
// (RL24) msb first, each byte acknowledged
// (RL25) bus reset frames recognised regardless of address
// (RL26) without avoidance interrupts pass directly
module sir_port #(
  parameter RST_WAIT = (`SIR_RST_WAIT_NS + `SIR_CLK_NS - 1) / `SIR_CLK_NS
) (
  input wire CORE_CLK, // core clock
  input wire RST, // async reset, high
  input wire [11:0] PADDR, // apb address
  input wire PSEL, // apb select
  input wire PENABLE, // apb enable
  input wire PWRITE, // apb direction
  input wire [31:0] PWDATA, // apb write data
  output reg [31:0] PRDATA, // apb read data
  output wire PREADY, // apb ready
  output wire PSLVERR, // apb error
  input wire SCL_I, // scl pin level
  output wire SCL_O, // scl drive value
  output wire SCL_OE, // scl drive enable
  input wire SDA_I, // sda pin level
  output wire SDA_O, // sda drive value
  output wire SDA_OE, // sda drive enable
  input wire [7:0] REG_RDATA, // register contents at REG_ADDR
  output wire [7:0] REG_ADDR, // register pointer
  input wire ADC_BUSY, // conversion running
  output reg ADC_TRIG, // conversion start pulse
  input wire INT_REQ, // conversion-end interrupt request pulse
  output reg INT_PULSE, // interrupt pulse out
  output reg BUS_RESET // one-cycle device reset pulse
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_AACK = 3'd2;
  localparam S_RIDX = 3'd3;
  localparam S_XACK = 3'd4;
  localparam S_SEND = 3'd5;
  localparam S_MACK = 3'd6;
  localparam S_SKIP = 3'd7;
  localparam CW = 16;
  reg [2:0] scl_s_q, sda_s_q;
  reg scl_q, sda_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg rd_q, wr_q, nack_q, drv_q, dval_q, str_q, hold_q;
  reg [2:0] trg_q;
  reg [7:0] ctrl_q;
  reg [6:0] taddr_q;
  reg [7:0] last_q;
  reg block_q, pend_q;
  reg [2:0] rseq_q;
  reg [CW-1:0] rcnt_q;
  reg rwait_q;
  reg [7:0] fbyte_q;
  reg fcnt_q;
  wire scl_f, sda_f, scl_r, scl_fl, start_c, stop_c;
  wire ca_en, str_en, proto1, in_map;
  wire wr_acc;
  // ==========================================================
  // pin sampling: a change counts when stages two and three agree
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], SCL_I};
      sda_s_q <= {sda_s_q[1:0], SDA_I};
      if (scl_s_q[1] == scl_s_q[2])
        scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_q <= sda_s_q[2];
    end
  assign scl_f = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
  assign sda_f = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
  assign scl_r = scl_f & ~scl_q;
  assign scl_fl = ~scl_f & scl_q;
  assign start_c = scl_f & scl_q & sda_q & ~sda_f; // RL8
  assign stop_c = scl_f & scl_q & ~sda_q & sda_f; // RL8
  assign ca_en = ~ctrl_q[`SIR_CTRL_CA_DIS];
  assign str_en = ctrl_q[`SIR_CTRL_STRETCH];
  assign proto1 = ctrl_q[`SIR_CTRL_PROTO];
  assign in_map = (ptr_q <= last_q);
  assign REG_ADDR = ptr_q;
  // ==========================================================
  // i2c target engine, msb first
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      st_q <= S_IDLE;
      bit_q <= 4'd0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      nack_q <= 1'b0;
      drv_q <= 1'b0;
      dval_q <= 1'b1;
      str_q <= 1'b0;
      hold_q <= 1'b0;
      trg_q <= 3'd0;
      ADC_TRIG <= 1'b0;
      fbyte_q <= 8'h00;
      fcnt_q <= 1'b0;
    end
    else
    begin
      ADC_TRIG <= 1'b0;
      fcnt_q <= 1'b0;
      if (start_c)
      begin
        // every start restarts addressing; no repeated start kept
        st_q <= S_ADDR; // RL22
        bit_q <= 4'd0;
        drv_q <= 1'b0;
        str_q <= 1'b0;
        nack_q <= 1'b0;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q <= S_IDLE;
        drv_q <= 1'b0;
        str_q <= 1'b0;
        nack_q <= 1'b0; // RL4
        rd_q <= 1'b0;
        wr_q <= 1'b0;
      end
      else
        case (st_q)
          S_IDLE: drv_q <= 1'b0;
          S_ADDR, S_RIDX:
            if (scl_r)
            begin
              sh_q <= {sh_q[6:0], sda_f}; // RL24
              bit_q <= bit_q + 4'd1;
            end
            else if (scl_fl && bit_q == 4'd8)
            begin
              bit_q <= 4'd0;
              if (st_q == S_ADDR)
              begin
                fbyte_q <= sh_q; // RL25
                fcnt_q <= 1'b1;
                if (sh_q[7:1] == taddr_q)
                begin
                  rd_q <= sh_q[0];
                  wr_q <= ~sh_q[0];
                  drv_q <= 1'b1;
                  dval_q <= 1'b0;
                  // stretch only on read address ack
                  str_q <= str_en & sh_q[0] & ADC_BUSY; // RL12 RL14 RL15
                  st_q <= S_AACK;
                end
                else
                  st_q <= S_SKIP;
              end
              else
              begin
                trg_q <= sh_q[7:5]; // RL23
                ptr_q <= {3'd0, sh_q[4:0]}; // RL1
                drv_q <= 1'b1;
                dval_q <= 1'b0;
                st_q <= S_XACK;
              end
            end
          S_AACK:
          begin
            if (str_q && !ADC_BUSY)
              str_q <= 1'b0; // RL13
            if (scl_fl && !str_q)
            begin
              drv_q <= 1'b0;
              if (wr_q || !proto1)
                st_q <= S_RIDX; // RL5
              else
              begin
                ptr_q <= 8'h00; // RL1 RL7
                hold_q <= 1'b1;
                st_q <= S_SEND;
              end
            end
          end
          S_XACK:
            if (scl_fl)
            begin
              drv_q <= 1'b0;
              if (rd_q)
              begin
                if (trg_q == `SIR_TRG_PRE_LO || trg_q == `SIR_TRG_PRE_HI)
                  ADC_TRIG <= 1'b1; // RL23
                hold_q <= 1'b1;
                st_q <= S_SEND;
              end
              else
                st_q <= S_SKIP;
            end
          S_SEND:
          begin
            if (hold_q)
            begin
              hold_q <= 1'b0;
              sh_q <= REG_RDATA;
              drv_q <= in_map & ~nack_q; // RL3 RL4
              dval_q <= REG_RDATA[7];
              bit_q <= 4'd1;
            end
            else if (scl_fl)
            begin
              if (bit_q == 4'd8)
              begin
                drv_q <= 1'b0;
                if (ptr_q[7:0] == `SIR_REG_AFTER && trg_q[2] && rd_q)
                  ADC_TRIG <= 1'b1; // RL23
                ptr_q <= ptr_q + 8'd1; // RL2
                st_q <= S_MACK;
              end
              else
              begin
                dval_q <= sh_q[7 - bit_q[2:0]];
                bit_q <= bit_q + 4'd1;
              end
            end
          end
          S_MACK:
            if (scl_r)
              nack_q <= nack_q | sda_f; // RL4
            else if (scl_fl)
            begin
              hold_q <= 1'b1;
              st_q <= S_SEND;
            end
          default: ;
        endcase
    end
  // released bit: pin floats high rather than driving one
  assign SDA_O = 1'b0;
  assign SDA_OE = drv_q & ~dval_q;
  assign SCL_O = 1'b0;
  assign SCL_OE = str_q; // RL12
  // ==========================================================
  // bus reset sequence ff, ff, 00, 00 then wait
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      rseq_q <= 3'd0;
      rwait_q <= 1'b0;
      rcnt_q <= {CW{1'b0}};
      BUS_RESET <= 1'b0;
    end
    else
    begin
      BUS_RESET <= 1'b0;
      if (fcnt_q)
      begin
        if (rseq_q < 3'd2 && fbyte_q == 8'hff)
          rseq_q <= rseq_q + 3'd1; // RL16 RL25
        else if ((rseq_q == 3'd2 || rseq_q == 3'd3) && fbyte_q == 8'h00)
          rseq_q <= rseq_q + 3'd1;
        else if (fbyte_q == 8'hff)
          rseq_q <= 3'd1;
        else
          rseq_q <= 3'd0;
      end
      else if (rseq_q == 3'd4 && stop_c)
      begin
        rseq_q <= 3'd0;
        rwait_q <= 1'b1;
        rcnt_q <= RST_WAIT[CW-1:0];
      end
      else if (rwait_q)
      begin
        if (rcnt_q <= {{(CW-1){1'b0}}, 1'b1})
        begin
          rwait_q <= 1'b0;
          BUS_RESET <= 1'b1; // RL16
        end
        else
          rcnt_q <= rcnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  // ==========================================================
  // collision avoidance on the interrupt output
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      block_q <= 1'b0;
      pend_q <= 1'b0;
      INT_PULSE <= 1'b0;
    end
    else
    begin
      INT_PULSE <= 1'b0;
      if (start_c)
        block_q <= 1'b1; // RL9 RL18
      else if (stop_c)
        block_q <= 1'b0; // RL10
      if (!ca_en)
      begin
        pend_q <= 1'b0;
        INT_PULSE <= INT_REQ; // RL26
      end
      else if ((block_q || start_c) && !stop_c)
      begin
        if (INT_REQ)
          pend_q <= 1'b1; // RL9
      end
      else if (pend_q || INT_REQ)
      begin
        pend_q <= 1'b0;
        INT_PULSE <= 1'b1; // RL10
      end
    end
  // ==========================================================
  // apb slave, zero wait states
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      ctrl_q <= `SIR_CTRL_RST;
      taddr_q <= `SIR_ADDR_RST;
      last_q <= `SIR_LAST_RST;
    end
    else if (BUS_RESET)
    begin
      ctrl_q <= `SIR_CTRL_RST;
      taddr_q <= `SIR_ADDR_RST;
      last_q <= `SIR_LAST_RST;
    end
    else if (wr_acc)
      case (PADDR)
        `SIR_OFF_CTRL: ctrl_q <= PWDATA[7:0]; // RL6
        `SIR_OFF_ADDR: taddr_q <= PWDATA[6:0];
        `SIR_OFF_LAST: last_q <= PWDATA[7:0];
        default: ;
      endcase
  always @(posedge CORE_CLK or posedge RST)
    if (RST)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      case (PADDR)
        `SIR_OFF_CTRL: PRDATA <= {24'h000000, ctrl_q};
        `SIR_OFF_STAT: PRDATA <= {16'h0000, ptr_q, block_q, pend_q,
          str_q, nack_q, 1'b0, st_q};
        `SIR_OFF_ADDR: PRDATA <= {25'h0000000, taddr_q};
        `SIR_OFF_LAST: PRDATA <= {24'h000000, last_q};
        default: PRDATA <= 32'h0000_0000;
      endcase
endmodule // sir_port
`default_nettype wire

/* shared/sir_map.vh */
// Purpose: constants for the sensor i2c read port
// Assumes: 25 MHz core clock, apb byte addresses
// Notes: register offsets are local choices
`ifndef SIR_MAP_VH
`define SIR_MAP_VH
// ==========================================================
// apb map
`define SIR_OFF_CTRL 12'h000
`define SIR_OFF_STAT 12'h004
`define SIR_OFF_ADDR 12'h008
`define SIR_OFF_LAST 12'h00c
// ==========================================================
// ctrl fields
`define SIR_CTRL_PROTO 4
`define SIR_CTRL_CA_DIS 5
`define SIR_CTRL_STRETCH 6
`define SIR_CTRL_RST 8'h00
`define SIR_ADDR_RST 7'h35
`define SIR_LAST_RST 8'h16
// ==========================================================
// trigger codes and timing
`define SIR_TRG_PRE_LO 3'b010
`define SIR_TRG_PRE_HI 3'b011
`define SIR_REG_AFTER 8'h05
`define SIR_RST_WAIT_NS 30000
`define SIR_CLK_NS 40
`endif

/* testbench/sir_port_props.sv */
// Purpose: pin-level assertions for the sensor read port
// Assumes: bus pins reach the core a few cycles late
// Notes: bus busy state is tracked from the raw pins
`include "sir_map.vh"
`timescale 1ns/10ps
`default_nettype none
module sir_port_props (
  input wire CORE_CLK, // core clock
  input wire RST, // async reset, high
  input wire [11:0] PADDR, // apb address
  input wire PSEL, // apb select
  input wire PENABLE, // apb enable
  input wire PWRITE, // apb direction
  input wire [31:0] PWDATA, // apb write data
  input wire PREADY, // apb ready
  input wire PSLVERR, // apb error
  input wire SCL_I, // scl level
  input wire SCL_OE, // scl pull low
  input wire SDA_I, // sda level
  input wire SDA_OE, // sda pull low
  input wire ADC_BUSY, // conversion running
  input wire ADC_TRIG, // conversion start
  input wire INT_REQ, // interrupt request
  input wire INT_PULSE, // interrupt out
  input wire BUS_RESET // device reset pulse
);
  logic scl_q, sda_q, busy_q, ca_dis_q;
  logic [2:0] quiet_q;
  wire start_w = scl_q && SCL_I && sda_q && !SDA_I;
  wire stop_w = scl_q && SCL_I && !sda_q && SDA_I;
  wire wr_w = PSEL && PENABLE && PWRITE && PREADY;
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      quiet_q <= 3'h0;
      ca_dis_q <= 1'b0;
    end
    else
    begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      if (start_w || stop_w)
        busy_q <= start_w;
      // saturates: only long settled bus states are judged
      quiet_q <= (start_w || stop_w) ? 3'h0 :
        quiet_q + 3'(quiet_q != 3'h7);
      if (BUS_RESET)
        ca_dis_q <= 1'b0;
      else if (wr_w && PADDR == `SIR_OFF_CTRL)
        ca_dis_q <= PWDATA[`SIR_CTRL_CA_DIS];
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_quiet_bus;
    !busy_q && quiet_q == 3'h7;
  endsequence
  sequence s_stretch_gone;
    ##[0:4] !SCL_OE;
  endsequence
  a_apb_ready: assert property (PREADY && !PSLVERR)
    else $error("apb slave stalled or flagged an error");
  a_stretch_cause: assert property
    ($rose(SCL_OE) |-> ADC_BUSY || $past(ADC_BUSY))
    else $error("scl held low without a conversion");
  a_stretch_end: assert property
    (SCL_OE && !ADC_BUSY |-> s_stretch_gone)
    else $error("scl still held after conversion end");
  a_int_direct: assert property
    (ca_dis_q && INT_REQ |=> INT_PULSE)
    else $error("interrupt not passed straight through");
  a_int_hold: assert property
    (!ca_dis_q && busy_q && quiet_q == 3'h7 |-> !INT_PULSE)
    else $error("interrupt pulse during a bus transfer");
  a_idle_release: assert property
    (s_quiet_bus |-> !SDA_OE && !SCL_OE)
    else $error("bus line pulled while bus is free");
  a_trig_pulse: assert property (ADC_TRIG |=> !ADC_TRIG)
    else $error("conversion start longer than one cycle");
  a_breset_idle: assert property
    ($rose(BUS_RESET) |-> !busy_q && !SDA_OE ##1 !BUS_RESET)
    else $error("device reset out of place");
endmodule // sir_port_props
bind sir_port sir_port_props sir_port_props_i (.CORE_CLK, .RST,
  .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PREADY, .PSLVERR,
  .SCL_I, .SCL_OE, .SDA_I, .SDA_OE, .ADC_BUSY, .ADC_TRIG,
  .INT_REQ, .INT_PULSE, .BUS_RESET);
`default_nettype wire

/* testbench/sir_mst.sv */
// Purpose: bus master model for the sensor read port
// Assumes: open-drain lines with pull-ups, 320 ns bit time
// Notes: scl stands high between frames
`timescale 1ns/10ps
`default_nettype none
module sir_mst (
  input wire logic scl_i, // resolved scl
  input wire logic sda_i, // resolved sda
  output logic scl_o, // 0 pulls scl low
  output logic sda_o // 0 pulls sda low
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ==========================================
  // bus conditions, each address gets its own start
  task automatic start;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask
  task automatic stop;
    sda_o = 1'b0;
    #80 scl_o = 1'b1;
    wait (scl_i);
    #80 sda_o = 1'b1;
    #160;
  endtask
  // waits out a target that holds scl low
  // long low phase: target reacts to a fall only after its synchroniser
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #160 scl_o = 1'b1;
    wait (scl_i);
    #40 r = sda_i;
    #80 scl_o = 1'b0;
    #40;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_o,
    output logic [7:0] r, output logic ack_i);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ack_o, ack_i);
  endtask
  task automatic bus_reset;
    logic [7:0] r;
    logic a;
    for (int k = 0; k < 4; k++)
    begin
      start;
      xfer(k < 2 ? 8'hff : 8'h00, 1'b1, r, a);
      stop;
    end
    #30000;
  endtask
endmodule // sir_mst
`default_nettype wire

/* testbench/test_sir_port.sv */
// Purpose: self-checking bench for the sensor read port
// Assumes: register contents are pointer xor 5a
// Notes: bus reset wait shortened through RST_WAIT
`include "sir_map.vh"
`timescale 1ns/10ps
`default_nettype none
module test_sir_port;
  typedef struct {logic one; logic [7:0] idx; int n; int trg;} sir_row_t;
  localparam logic [7:0] rd_adr = {`SIR_ADDR_RST, 1'b1};
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] PADDR = 12'h000;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [31:0] PWDATA = 32'h0;
  logic ADC_BUSY = 1'b0;
  logic INT_REQ = 1'b0;
  wire [31:0] PRDATA;
  wire [7:0] REG_ADDR;
  wire PREADY, PSLVERR, SCL_OE, SDA_OE, ADC_TRIG, INT_PULSE, BUS_RESET;
  wire m_scl, m_sda;
  wire SCL_I = m_scl && !SCL_OE;
  wire SDA_I = m_sda && !SDA_OE;
  wire [7:0] REG_RDATA = REG_ADDR ^ 8'h5a;
  int miscompares = 0, checks = 0;
  int trg_n = 0, int_n = 0, rst_n = 0, oe_n = 0;
  sir_row_t rows[8] = '{'{0, 8'h00, 3, 0}, '{0, 8'h54, 4, 1},
    '{0, 8'h7f, 2, 1}, '{0, 8'h83, 4, 1}, '{0, 8'ha0, 3, 0},
    '{0, 8'hc5, 2, 1}, '{0, 8'h20, 2, 0}, '{1, 8'h00, 8, 0}};
  logic [11:0] offs[4] = '{`SIR_OFF_CTRL, `SIR_OFF_ADDR,
    `SIR_OFF_LAST, 12'h010};
  logic [31:0] vals[4] = '{`SIR_CTRL_RST, `SIR_ADDR_RST,
    `SIR_LAST_RST, 32'h0};
  sir_port #(.RST_WAIT(4)) sir_port_i (.CORE_CLK, .RST, .PADDR, .PSEL,
    .PENABLE, .PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SCL_I,
    .SCL_O(), .SCL_OE, .SDA_I, .SDA_O(), .SDA_OE, .REG_RDATA,
    .REG_ADDR, .ADC_BUSY, .ADC_TRIG, .INT_REQ, .INT_PULSE, .BUS_RESET);
  sir_mst sir_mst_i (.scl_i(SCL_I), .sda_i(SDA_I), .scl_o(m_scl),
    .sda_o(m_sda));
  always #20 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    trg_n <= trg_n + ADC_TRIG;
    int_n <= int_n + INT_PULSE;
    rst_n <= rst_n + BUS_RESET;
    oe_n <= oe_n + SCL_OE;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1)
      @(posedge CORE_CLK);
    r = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd_frame(input logic one, input logic [7:0] idx,
    input int n);
    logic [7:0] r, p;
    logic a;
    p = one ? 8'h00 : {3'h0, idx[4:0]};
    sir_mst_i.start;
    sir_mst_i.xfer(rd_adr, 1'b1, r, a);
    chk(a, 0);
    if (!one)
    begin
      sir_mst_i.xfer(idx, 1'b1, r, a);
      chk(a, 0);
    end
    for (int i = 0; i < n; i++)
    begin
      sir_mst_i.xfer(8'hff, i == n - 1, r, a);
      chk(r, p > `SIR_LAST_RST ? 8'hff : p ^ 8'h5a);
      p++;
    end
    sir_mst_i.stop;
  endtask
  task automatic conclude;
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    miscompares++;
    conclude;
  end
  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic [7:0] d;
    logic a;
    int b;
    repeat (4) @(posedge CORE_CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    sir_mst_i.bus_reset;
    chk(rst_n, 1);
    apb(1'b1, 12'h010, 32'hffffffff, r);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0, r);
      chk(r, vals[i]);
    end
    foreach (rows[k])
    begin
      apb(1'b1, `SIR_OFF_CTRL, 32'(rows[k].one) << `SIR_CTRL_PROTO, r);
      b = trg_n;
      rd_frame(rows[k].one, rows[k].idx, rows[k].n);
      chk(trg_n - b, rows[k].trg);
      $display("row %0d done", k);
    end
    // refused byte: the line stays released until the stop
    apb(1'b1, `SIR_OFF_CTRL, 32'h0, r);
    sir_mst_i.start;
    sir_mst_i.xfer(rd_adr, 1'b1, d, a);
    sir_mst_i.xfer(8'h00, 1'b1, d, a);
    sir_mst_i.xfer(8'hff, 1'b1, d, a);
    sir_mst_i.xfer(8'hff, 1'b0, d, a);
    chk(d, 8'hff);
    sir_mst_i.stop;
    rd_frame(1'b0, 8'h01, 1);
    $display("refusal test done");
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `SIR_OFF_CTRL, (32'h1 << `SIR_CTRL_STRETCH) |
        (32'(m) << `SIR_CTRL_PROTO), r);
      ADC_BUSY <= 1'b1;
      b = oe_n;
      fork
        rd_frame(m == 1, 8'h00, 2);
        begin
          repeat (300) @(posedge CORE_CLK);
          chk(oe_n - b > 100, 1);
          ADC_BUSY <= 1'b0;
        end
      join
      $display("stretch test %0d done", m);
    end
    ADC_BUSY <= 1'b1;
    b = oe_n;
    sir_mst_i.start;
    sir_mst_i.xfer({`SIR_ADDR_RST, 1'b0}, 1'b1, d, a);
    sir_mst_i.xfer(8'h11, 1'b1, d, a);
    sir_mst_i.stop;
    chk(oe_n - b, 0);
    ADC_BUSY <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `SIR_OFF_CTRL, 32'(m) << `SIR_CTRL_CA_DIS, r);
      b = int_n;
      sir_mst_i.start;
      sir_mst_i.xfer(8'h20, 1'b1, d, a);
      @(posedge CORE_CLK);
      INT_REQ <= 1'b1;
      @(posedge CORE_CLK);
      INT_REQ <= 1'b0;
      repeat (20) @(posedge CORE_CLK);
      chk(int_n - b, m);
      sir_mst_i.stop;
      repeat (10) @(posedge CORE_CLK);
      chk(int_n - b, 1);
      $display("interrupt test %0d done", m);
    end
    apb(1'b1, `SIR_OFF_ADDR, 32'h22, r);
    apb(1'b1, `SIR_OFF_CTRL, 32'h70, r);
    b = rst_n;
    sir_mst_i.bus_reset;
    chk(rst_n - b, 1);
    apb(1'b0, `SIR_OFF_ADDR, 32'h0, r);
    chk(r, `SIR_ADDR_RST);
    apb(1'b0, `SIR_OFF_CTRL, 32'h0, r);
    chk(r, `SIR_CTRL_RST);
    $display("bus reset test done");
    conclude;
  end
endmodule // test_sir_port
`default_nettype wire
